// ---- design/srx_exec.sv ----
// Decode and execute for rotate-insert, both system calls and subtract-immediate
`timescale 1ns/10ps
module srx_exec (
    // Clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // Issued instruction and its address
    input wire logic instr_valid,
    input wire logic [31:0] instr,
    input wire logic [31:0] instr_addr,
    // Register file read ports
    output logic [4:0] rd_a_sel,
    output logic [4:0] rd_b_sel,
    output logic [4:0] rd_c_sel,
    input wire logic [31:0] rd_a_data,
    input wire logic [31:0] rd_b_data,
    input wire logic [31:0] rd_c_data,
    // Machine state and exception register inputs
    input wire logic [63:0] machine_state_word,
    input wire logic [31:0] xer_in,
    // Register file write port
    output logic gpr_we,
    output logic [4:0] gpr_wsel,
    output logic [31:0] gpr_wdata,
    // State outputs
    output logic [3:0] cond_field_zero,
    output logic [31:0] xer_out,
    output logic xer_we,
    output logic [31:0] save_pc_reg,
    output logic [31:0] save_state_reg,
    output logic [31:0] link_reg,
    output logic [63:0] count_reg,
    output logic syscall_irq
);
    import srx_pkg::*;

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic gpr_we;
        logic [4:0] gpr_wsel;
        logic [31:0] gpr_wdata;
        logic [3:0] cr0;
        logic [31:0] xer;
        logic xer_we;
        logic [31:0] save_pc;
        logic [31:0] save_state;
        logic [31:0] link;
        logic [63:0] count;
        logic irq;
    } srx_state_type;

    srx_state_type s_q;
    srx_state_type s_d;
    srx_op_type op;
    logic [31:0] rot_res;
    logic [32:0] sum;
    logic [31:0] imm_ext;
    logic [31:0] next_addr;
    logic [3:0] flags;

    // ----------------------------------------
    // Operand selection
    // ----------------------------------------
    // Port a: source/operand, b: amount, c: destination old value
    assign rd_a_sel = (op == SRX_OP_SUBIMM) ? srx_field5(instr, POS_DST)
                                            : srx_field5(instr, POS_SRC);
    assign rd_b_sel = srx_field5(instr, POS_AMT);
    assign rd_c_sel = srx_field5(instr, POS_DST);

    srx_decode u_decode (
        .instr(instr),
        .valid(instr_valid),
        .op(op)
    );

    srx_rotins u_rotins (
        .src_val(rd_a_data),
        .dst_val(rd_c_data),
        .amt_val(rd_b_data),
        .result(rot_res)
    );

    // Field already holds the negated operand, so an add does the subtract
    assign imm_ext = {{16{instr[15]}}, instr[15:0]};
    assign sum = {1'b0, rd_a_data} + {1'b0, imm_ext};
    assign next_addr = instr_addr + 32'h00000004;
    // Signed compare with zero; sticky takes the current summary bit
    assign flags = {rot_res[31], ~rot_res[31] & (|rot_res), ~(|rot_res),
                    xer_in[XER_SO]};

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.gpr_we = 1'b0;
        s_d.xer_we = 1'b0;
        s_d.irq = 1'b0;
        s_d.xer = xer_in;
        unique case (op)
            SRX_OP_ROTINS: begin
                s_d.gpr_we = 1'b1;
                s_d.gpr_wsel = srx_field5(instr, POS_DST);
                s_d.gpr_wdata = rot_res;
                // Exception register is never written here
                if (instr[31 - POS_REC]) begin
                    s_d.cr0 = flags;
                end
            end
            SRX_OP_PLAIN: begin
                s_d.irq = 1'b1;
                s_d.save_pc = next_addr;
                // Undefined positions are driven to zero for determinism
                s_d.save_state = machine_state_word[31:0] & SAVE_MASK32;
            end
            SRX_OP_VECT: begin
                s_d.irq = 1'b1;
                s_d.link = next_addr;
                s_d.count = machine_state_word & SAVE_MASK64;
            end
            SRX_OP_SUBIMM: begin
                s_d.gpr_we = 1'b1;
                s_d.gpr_wsel = srx_field5(instr, POS_SRC);
                s_d.gpr_wdata = sum[31:0];
                s_d.xer_we = 1'b1;
                s_d.xer[XER_CA] = sum[32];
                // Condition field zero left as is
            end
            default: begin
            end
        endcase
    end

    // Machine state word is only an input: no path writes it
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            s_q <= '{gpr_we: 1'b0, gpr_wsel: 5'h00, gpr_wdata: WORD_RESET, cr0: CR0_RESET,
                     xer: XER_RESET, xer_we: 1'b0, save_pc: WORD_RESET,
                     save_state: WORD_RESET, link: WORD_RESET, count: WIDE_RESET,
                     irq: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    assign gpr_we = s_q.gpr_we;
    assign gpr_wsel = s_q.gpr_wsel;
    assign gpr_wdata = s_q.gpr_wdata;
    assign cond_field_zero = s_q.cr0;
    assign xer_out = s_q.xer;
    assign xer_we = s_q.xer_we;
    assign save_pc_reg = s_q.save_pc;
    assign save_state_reg = s_q.save_state;
    assign link_reg = s_q.link;
    assign count_reg = s_q.count;
    assign syscall_irq = s_q.irq;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    sequence plain_issue_s;
        op == SRX_OP_PLAIN;
    endsequence
    sequence vect_issue_s;
        op == SRX_OP_VECT;
    endsequence

    rotins_write_a: assert property (@(posedge clock) disable iff (!arst_n)
        op == SRX_OP_ROTINS |=> gpr_we && gpr_wdata ==
            (($past(rd_c_data) & ~(32'h80000000 >> $past(rd_b_data[4:0])))
            | ({$past(rd_a_data[31]), 31'h0} >> $past(rd_b_data[4:0]))))
        else $error("rotate-insert result not written");
    rotins_keep_a: assert property (@(posedge clock) disable iff (!arst_n)
        op == SRX_OP_ROTINS |=> gpr_wsel == $past(instr[20:16]))
        else $error("rotate-insert wrong destination");
    rotins_xer_a: assert property (@(posedge clock) disable iff (!arst_n)
        op == SRX_OP_ROTINS |=> !xer_we)
        else $error("rotate-insert touched exception register");
    record_cr_a: assert property (@(posedge clock) disable iff (!arst_n)
        op == SRX_OP_ROTINS && !instr[0] |=> $stable(cond_field_zero))
        else $error("condition field changed without record flag");
    cr_sticky_a: assert property (@(posedge clock) disable iff (!arst_n)
        op == SRX_OP_ROTINS && instr[0] |=> cond_field_zero[0] == $past(xer_in[XER_SO]))
        else $error("sticky flag not copied");
    plain_call_a: assert property (@(posedge clock) disable iff (!arst_n)
        plain_issue_s |=> syscall_irq && save_pc_reg == $past(instr_addr) + 32'h4)
        else $error("plain call save address wrong");
    plain_state_a: assert property (@(posedge clock) disable iff (!arst_n)
        plain_issue_s |=> (save_state_reg & SAVE_MASK32) ==
            ($past(machine_state_word[31:0]) & SAVE_MASK32))
        else $error("plain call state not saved");
    vect_call_a: assert property (@(posedge clock) disable iff (!arst_n)
        vect_issue_s |=> syscall_irq && link_reg == $past(instr_addr) + 32'h4)
        else $error("vectored call link wrong");
    vect_state_a: assert property (@(posedge clock) disable iff (!arst_n)
        vect_issue_s |=> (count_reg & SAVE_MASK64) == ($past(machine_state_word) & SAVE_MASK64))
        else $error("vectored call state not saved");
    subimm_carry_a: assert property (@(posedge clock) disable iff (!arst_n)
        op == SRX_OP_SUBIMM |=> xer_we && xer_out[XER_CA] == $past(sum[32])
            && gpr_wdata == $past(rd_a_data) + $past(imm_ext))
        else $error("subtract-immediate carry or sum wrong");
    subimm_cr_a: assert property (@(posedge clock) disable iff (!arst_n)
        op == SRX_OP_SUBIMM |=> $stable(cond_field_zero))
        else $error("subtract-immediate changed condition field");
endmodule // srx_exec

// ---- design/srx_pkg.sv ----
// Constants, encodings and field positions of the rotate-insert, system call and subtract block
// Contract
// - Rotate-insert: opcode 31, extended 537, fields
// - Rotation count from amount bits 27-31 only
// - Source bit 0 moved right, others kept
// - Rotate-insert never changes exception register
// - Record flag set updates condition field zero
// - Plain call: interrupt, next address to save_pc
// - Plain call saves state bits 0,5-9,16-31
// - Plain call: save bits 1-4,10-15 undefined
// - Calls: opcode 17, tier 20-26, bit 30/31
// - Vectored call: interrupt, next address to link
// - Vectored call saves state into count register
// - Vectored: count bits 33-36,42-47 undefined
// - System calls never modify machine state word
// - Subtract-immediate opcode 12 adds sign-extended field
// - Subtract-immediate sets carry from addition
// - Subtract-immediate leaves condition field zero alone
package srx_pkg;
    // Bit numbering: bit 0 is the most significant bit of the word
    localparam int WORD_W = 32;
    localparam int WIDE_W = 64;
    localparam int REG_AW = 5;
    localparam logic [5:0] OPC_ROTINS = 6'h1f;
    localparam logic [9:0] XOP_ROTINS = 10'h219;
    localparam logic [5:0] OPC_SYSCALL = 6'h11;
    localparam logic [5:0] OPC_SUBIMM = 6'h0c;
    // Field positions, counted from bit 0 at the left
    localparam int POS_OPC = 0;
    localparam int POS_SRC = 6;
    localparam int POS_DST = 11;
    localparam int POS_AMT = 16;
    localparam int POS_XOP = 21;
    localparam int POS_REC = 31;
    localparam int POS_TIER = 20;
    localparam int POS_PLAIN = 30;
    localparam int POS_VECT = 31;
    localparam int POS_COUNT = 27;
    // Kept state bit masks, left-numbered: 0, 5-9, 16-31 and 0-32, 37-41, 48-63
    localparam logic [31:0] SAVE_MASK32 = 32'h87c0ffff;
    localparam logic [63:0] SAVE_MASK64 = 64'hffffffff87c0ffff;
    // Exception register bits in the usual right-numbered word: summary and carry
    localparam int XER_SO = 31;
    localparam int XER_CA = 29;
    localparam logic [3:0] CR0_RESET = 4'h0;
    localparam logic [31:0] XER_RESET = 32'h00000000;
    localparam logic [63:0] WIDE_RESET = 64'h0;
    localparam logic [31:0] WORD_RESET = 32'h0;
    typedef enum logic [2:0] {
        SRX_OP_NONE, SRX_OP_ROTINS, SRX_OP_PLAIN, SRX_OP_VECT, SRX_OP_SUBIMM
    } srx_op_type;
    // Field extraction with left-numbered bit positions
    function automatic logic [4:0] srx_field5(input logic [31:0] w, input int pos);
        srx_field5 = w[31 - pos -: 5];
    endfunction
endpackage

// ---- design/srx_decode.sv ----
// Instruction classifier for the four handled encodings
`timescale 1ns/10ps
module srx_decode (
    // Instruction
    input wire logic [31:0] instr,
    input wire logic valid,
    // Class
    output srx_pkg::srx_op_type op
);
    import srx_pkg::*;
    logic [5:0] opc;
    logic [9:0] xop;
    assign opc = instr[31 - POS_OPC -: 6];
    assign xop = instr[31 - POS_XOP -: 10];
    always_comb begin
        op = SRX_OP_NONE;
        if (valid) begin
            if (opc == OPC_ROTINS && xop == XOP_ROTINS) begin
                op = SRX_OP_ROTINS;
            end else if (opc == OPC_SYSCALL && instr[31 - POS_PLAIN]) begin
                op = SRX_OP_PLAIN;
            end else if (opc == OPC_SYSCALL && instr[31 - POS_VECT]) begin
                op = SRX_OP_VECT;
            end else if (opc == OPC_SUBIMM) begin
                op = SRX_OP_SUBIMM;
            end
        end
    end
endmodule // srx_decode

// ---- design/srx_rotins.sv ----
// Rotate-right-insert-bit datapath
`timescale 1ns/10ps
module srx_rotins (
    // Operands
    input wire logic [31:0] src_val,
    input wire logic [31:0] dst_val,
    input wire logic [31:0] amt_val,
    // Result
    output logic [31:0] result
);
    import srx_pkg::*;
    logic [4:0] count;
    logic [31:0] pick;
    // Only left-numbered bits 27-31 (the low five) count; the rest is ignored
    assign count = amt_val[31 - POS_COUNT -: 5];
    // Left bit position n is right index 31-n
    assign pick = 32'h80000000 >> count;
    // A zero count lands back on bit 0 itself
    assign result = (dst_val & ~pick) | (src_val[31] ? pick : 32'h0);
endmodule // srx_rotins

// ---- tb/testbench.sv ----
// Self-checking bench for the rotate-insert, system call and subtract-immediate block
`timescale 1ns/10ps
module testbench;
    import srx_pkg::*;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic clock = 1'b0;
    logic arst_n = 1'b0;
    logic instr_valid = 1'b0;
    logic [31:0] instr = 32'h0;
    logic [31:0] instr_addr = 32'h0;
    logic [4:0] rd_a_sel, rd_b_sel, rd_c_sel;
    logic [31:0] rd_a_data, rd_b_data, rd_c_data;
    logic [63:0] machine_state_word = 64'h0;
    logic [31:0] xer_in = 32'h0;
    logic gpr_we, xer_we, syscall_irq;
    logic [4:0] gpr_wsel;
    logic [31:0] gpr_wdata, xer_out, save_pc_reg, save_state_reg, link_reg;
    logic [3:0] cond_field_zero;
    logic [63:0] count_reg;
    logic [31:0] regs [32];
    int mismatches = 0;
    int checked = 0;
    int cycles = 0;
    // Register file answers in the same cycle, as the core's file does
    assign rd_a_data = regs[rd_a_sel];
    assign rd_b_data = regs[rd_b_sel];
    assign rd_c_data = regs[rd_c_sel];
    srx_exec DUT (.clock(clock), .arst_n(arst_n), .instr_valid(instr_valid), .instr(instr),
        .instr_addr(instr_addr), .rd_a_sel(rd_a_sel), .rd_b_sel(rd_b_sel), .rd_c_sel(rd_c_sel),
        .rd_a_data(rd_a_data), .rd_b_data(rd_b_data), .rd_c_data(rd_c_data),
        .machine_state_word(machine_state_word), .xer_in(xer_in), .gpr_we(gpr_we),
        .gpr_wsel(gpr_wsel), .gpr_wdata(gpr_wdata), .cond_field_zero(cond_field_zero),
        .xer_out(xer_out), .xer_we(xer_we), .save_pc_reg(save_pc_reg),
        .save_state_reg(save_state_reg), .link_reg(link_reg), .count_reg(count_reg),
        .syscall_irq(syscall_irq));
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    initial begin
        forever #12.5 clock = ~clock;
    end
    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop();
        if (mismatches == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // One instruction; effects are sampled just after the taking edge
    task automatic issue(input logic [31:0] w, input logic [31:0] addr);
        @(posedge clock);
        instr_valid <= 1'b1;
        instr <= w;
        instr_addr <= addr;
        @(posedge clock);
        instr_valid <= 1'b0;
        #1;
    endtask
    function automatic logic [31:0] rot_word(input logic rc);
        rot_word = {OPC_ROTINS, 5'd5, 5'd4, 5'd6, XOP_ROTINS, rc};
    endfunction
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic test_rotins();
        // Upper amount bits are noise; only the low five count
        regs[5] = 32'hb0043000;
        regs[6] = 32'hffffffe4;
        regs[4] = 32'h00000000;
        xer_in = 32'h80000000;
        issue(rot_word(1'b1), 32'h100);
        check(gpr_we, 1'b1);
        check(gpr_wsel, 5'd4);
        check(gpr_wdata, 32'h08000000);
        check(cond_field_zero, 4'h5);
        check(xer_we, 1'b0);
        regs[5] = 32'h80000000;
        regs[6] = 32'h00000000;
        xer_in = 32'h00000000;
        issue(rot_word(1'b1), 32'h104);
        check(gpr_wdata, 32'h80000000);
        check(cond_field_zero, 4'h8);
        regs[5] = 32'h00000000;
        regs[6] = 32'h00000004;
        regs[4] = 32'hffffffff;
        issue(rot_word(1'b0), 32'h108);
        check(gpr_wdata, 32'hf7ffffff);
        check(cond_field_zero, 4'h8);
        check(xer_we, 1'b0);
    endtask
    task automatic test_calls();
        machine_state_word = 64'h0123456789abcdef;
        // Producer side: tier 1 here, tier 0 on the vectored form
        issue({OPC_SYSCALL, 14'h0, 7'd1, 3'h0, 1'b1, 1'b0}, 32'h200);
        check(syscall_irq, 1'b1);
        check(save_pc_reg, 32'h204);
        check(save_state_reg & SAVE_MASK32, 32'h89abcdef & SAVE_MASK32);
        @(posedge clock);
        #1;
        check(syscall_irq, 1'b0);
        issue({OPC_SYSCALL, 14'h0, 7'd0, 3'h0, 1'b0, 1'b1}, 32'h300);
        check(syscall_irq, 1'b1);
        check(link_reg, 32'h304);
        check(count_reg & SAVE_MASK64, 64'h0123456789abcdef & SAVE_MASK64);
        check(save_pc_reg, 32'h204);
        // Short plain form: tier field left at zero by the producer
        issue({OPC_SYSCALL, 14'h0, 7'd0, 3'h0, 1'b1, 1'b0}, 32'h600);
        check(save_pc_reg, 32'h604);
        check(link_reg, 32'h304);
    endtask
    task automatic test_subimm();
        regs[7] = 32'h00000010;
        xer_in = 32'h00000000;
        issue({OPC_SUBIMM, 5'd9, 5'd7, 16'hfff0}, 32'h400);
        check(gpr_wsel, 5'd9);
        check(gpr_wdata, 32'h0);
        check(xer_we, 1'b1);
        check(xer_out, 32'h20000000);
        check(cond_field_zero, 4'h8);
        regs[7] = 32'h00000000;
        xer_in = 32'h20000000;
        issue({OPC_SUBIMM, 5'd9, 5'd7, 16'h0800}, 32'h404);
        check(gpr_wdata, 32'h00000800);
        check(xer_out, 32'h00000000);
    endtask
    task automatic test_ignored();
        // Wrong extended opcode and an unissued call leave everything alone
        issue({OPC_ROTINS, 5'd5, 5'd4, 5'd6, 10'h218, 1'b1}, 32'h500);
        check(gpr_we, 1'b0);
        check(cond_field_zero, 4'h8);
        @(posedge clock);
        instr <= {OPC_SYSCALL, 14'h0, 7'd0, 3'h0, 1'b1, 1'b0};
        @(posedge clock);
        #1;
        check(syscall_irq, 1'b0);
    endtask
    // ------------------------------------------------------------
    // Main sequence and hang guard
    // ------------------------------------------------------------
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            mismatches++;
            report_and_stop();
        end
    end
    initial begin
        for (int i = 0; i < 32; i++) begin
            regs[i] = 32'h0;
        end
        repeat (20) @(posedge clock);
        arst_n <= 1'b1;
        #1;
        check(syscall_irq, 1'b0);
        check(count_reg, 64'h0);
        test_rotins();
        test_calls();
        test_subimm();
        test_ignored();
        report_and_stop();
    end
endmodule // testbench
